// >>> servo_gain_switch_filter_ctrl.sv
// Gain set selector, filter enables and register file of the servo control law.
// Contract
// - Condition 0 or 4 always selects the first gain set, condition 1 always the second.
// - Condition 2 selects the second gain set while the gain switch input is active.
// - Condition 3 switches on torque command variation in 0.05 % per 166 us, with the delay.
// - Conditions 5 and 9 use velocity command and motor speed; 7 and 8 use flags and the delay.
// - Condition 6 switches on position deviation in encoder pulses, with the delay.
// - The delay applies only on return from the second gain set to the first.
// - The torque filter cutoff is 1/(2*pi*tc*0.00001) Hz.
// - The adaptive notch runs only with tuning setup 1, 2, 3 or 7 and control mode 2.
// - The adaptive filter index register reports the adapted index and ignores writes.
// - Anti-vibration filtering runs only in control mode 0 or 2.
// - Control mode 0 disables real-time tuning and the first notch filter.
// - A damping frequency of 0 to 99 leaves the anti-vibration filter off.
module servo_gain_switch_filter_ctrl
  import servo_gain_pkg::*;
#(
  parameter int VAR_WINDOW = servo_gain_pkg::VAR_WINDOW_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // AXI4-Lite write address and data
  input wire logic [servo_gain_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // AXI4-Lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [servo_gain_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Gain switch pin and monitored quantities
  input wire logic gainSwitchPin,
  input wire logic signed [servo_gain_pkg::DATA_W-1:0] torqueCmd,
  input wire logic signed [servo_gain_pkg::DATA_W-1:0] velocityCmd,
  input wire logic signed [servo_gain_pkg::DATA_W-1:0] motorSpeed,
  input wire logic signed [servo_gain_pkg::DATA_W-1:0] positionDeviation,
  input wire logic positionCmdActive,
  input wire logic positioningDone,
  input wire logic [servo_gain_pkg::DATA_W-1:0] adaptedIndex,
  // Control outputs
  output logic secondGain,
  output logic signed [servo_gain_pkg::DATA_W-1:0] torqueFiltered,
  output logic adaptiveNotchEn,
  output logic firstNotchEn,
  output logic realtimeTuningEn,
  output logic antiVibEn,
  output logic [servo_gain_pkg::DATA_W-1:0] notchFreq,
  output logic [servo_gain_pkg::DATA_W-1:0] notchWidth,
  output logic [servo_gain_pkg::DATA_W-1:0] vibFreq,
  output logic [servo_gain_pkg::DATA_W-1:0] vibFilter
);
  import servo_gain_pkg::*;

  localparam int WCW = $clog2(VAR_WINDOW + 1);
  localparam int QW = DATA_W + 2;
  if (VAR_WINDOW < 2) begin : g_chk
    $error("servo_gain_switch_filter_ctrl: variation window too short");
  end

  // ==========================================================================
  // Register storage
  // ==========================================================================
  logic [DATA_W-1:0] condSel;
  logic [DATA_W-1:0] switchDelay;
  logic [DATA_W-1:0] switchLevel;
  logic [DATA_W-1:0] switchHyst;
  logic [DATA_W-1:0] firstTc;
  logic [DATA_W-1:0] secondTc;
  logic [DATA_W-1:0] tuningSetup;
  logic [DATA_W-1:0] controlMode;
  logic [DATA_W-1:0] adaptIdx;
  logic [DATA_W-1:0] statusWord;

  // ==========================================================================
  // AXI4-Lite write channel
  // ==========================================================================
  logic awHeld;
  logic wHeld;
  logic [ADDR_W-1:0] wrAddr;
  logic [31:0] wrData;
  logic [3:0] wrStrb;
  logic doWrite;
  logic wrHit;
  assign doWrite = awHeld && wHeld && !bvalid;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awready <= 1'b1;
      wready <= 1'b1;
      wrAddr <= '0;
      wrData <= '0;
      wrStrb <= '0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        awHeld <= 1'b1;
        awready <= 1'b0;
        wrAddr <= awaddr;
      end
      if (wvalid && wready) begin
        wHeld <= 1'b1;
        wready <= 1'b0;
        wrData <= wdata;
        wrStrb <= wstrb;
      end
      if (doWrite) begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wrHit ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // Only the two low byte lanes carry data; the upper lanes are ignored.
  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old, input logic [31:0] d,
                                               input logic [3:0] s);
    merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  always_comb begin
    case (wrAddr)
      OFS_COND_SEL, OFS_DELAY, OFS_LEVEL, OFS_HYST, OFS_TC1, OFS_TC2, OFS_RT_TUNE, OFS_ADAPT_IDX,
      OFS_CTRL_MODE, OFS_NOTCH_FREQ, OFS_NOTCH_WIDTH, OFS_VIB_FREQ, OFS_VIB_FILTER, OFS_STATUS: begin
        wrHit = 1'b1;
      end
      default: begin
        wrHit = 1'b0;
      end
    endcase
  end

  // The adaptive index and status words have no store here, so writes to them
  // are answered OKAY and change nothing.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      condSel <= RST_COND_SEL;
      switchDelay <= RST_DELAY;
      switchLevel <= RST_LEVEL;
      switchHyst <= RST_HYST;
      firstTc <= RST_TC;
      secondTc <= RST_TC;
      tuningSetup <= RST_ZERO;
      controlMode <= RST_ZERO;
      notchFreq <= RST_ZERO;
      notchWidth <= RST_ZERO;
      vibFreq <= RST_ZERO;
      vibFilter <= RST_ZERO;
    end else if (doWrite) begin
      case (wrAddr)
        OFS_COND_SEL: condSel <= merge(condSel, wrData, wrStrb);
        OFS_DELAY: switchDelay <= merge(switchDelay, wrData, wrStrb);
        OFS_LEVEL: switchLevel <= merge(switchLevel, wrData, wrStrb);
        OFS_HYST: switchHyst <= merge(switchHyst, wrData, wrStrb);
        OFS_TC1: firstTc <= merge(firstTc, wrData, wrStrb);
        OFS_TC2: secondTc <= merge(secondTc, wrData, wrStrb);
        OFS_RT_TUNE: tuningSetup <= merge(tuningSetup, wrData, wrStrb);
        OFS_CTRL_MODE: controlMode <= merge(controlMode, wrData, wrStrb);
        OFS_NOTCH_FREQ: notchFreq <= merge(notchFreq, wrData, wrStrb);
        OFS_NOTCH_WIDTH: notchWidth <= merge(notchWidth, wrData, wrStrb);
        OFS_VIB_FREQ: vibFreq <= merge(vibFreq, wrData, wrStrb);
        OFS_VIB_FILTER: vibFilter <= merge(vibFilter, wrData, wrStrb);
        default: begin
        end
      endcase
    end
  end

  // ==========================================================================
  // AXI4-Lite read channel
  // ==========================================================================
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rresp <= RESP_OKAY;
      case (araddr)
        OFS_COND_SEL: rdata <= {16'h0000, condSel};
        OFS_DELAY: rdata <= {16'h0000, switchDelay};
        OFS_LEVEL: rdata <= {16'h0000, switchLevel};
        OFS_HYST: rdata <= {16'h0000, switchHyst};
        OFS_TC1: rdata <= {16'h0000, firstTc};
        OFS_TC2: rdata <= {16'h0000, secondTc};
        OFS_RT_TUNE: rdata <= {16'h0000, tuningSetup};
        OFS_ADAPT_IDX: rdata <= {16'h0000, adaptIdx};
        OFS_CTRL_MODE: rdata <= {16'h0000, controlMode};
        OFS_NOTCH_FREQ: rdata <= {16'h0000, notchFreq};
        OFS_NOTCH_WIDTH: rdata <= {16'h0000, notchWidth};
        OFS_VIB_FREQ: rdata <= {16'h0000, vibFreq};
        OFS_VIB_FILTER: rdata <= {16'h0000, vibFilter};
        OFS_STATUS: rdata <= {16'h0000, statusWord};
        default: begin
          rdata <= '0;
          rresp <= RESP_SLVERR;
        end
      endcase
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  // ==========================================================================
  // Gain switch pin synchroniser
  // ==========================================================================
  logic pinMeta;
  logic pinSync2;
  logic pinSync3;
  logic gainInput;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pinMeta <= 1'b0;
      pinSync2 <= 1'b0;
      pinSync3 <= 1'b0;
      gainInput <= 1'b0;
    end else begin
      pinMeta <= gainSwitchPin;
      pinSync2 <= pinMeta;
      pinSync3 <= pinSync2;
      if (pinSync2 == pinSync3) begin
        gainInput <= pinSync3;
      end
    end
  end

  // ==========================================================================
  // 166 us window: torque variation and delay tick
  // ==========================================================================
  logic [WCW-1:0] windowCnt;
  logic windowTick;
  logic signed [DATA_W-1:0] torquePrev;
  logic [QW-1:0] torqueVar;
  logic signed [DATA_W:0] torqueStep;
  assign windowTick = (windowCnt == WCW'(VAR_WINDOW - 1));
  assign torqueStep = {torqueCmd[DATA_W-1], torqueCmd} - {torquePrev[DATA_W-1], torquePrev};

  // Variation is the torque change over one window, in 0.05 % units per window.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      windowCnt <= '0;
      torquePrev <= '0;
      torqueVar <= '0;
    end else begin
      windowCnt <= windowTick ? '0 : windowCnt + 1'b1;
      if (windowTick) begin
        torquePrev <= torqueCmd;
        torqueVar <= torqueStep[DATA_W] ? QW'(-torqueStep) : QW'(torqueStep);
      end
    end
  end

  // ==========================================================================
  // Switching condition evaluation
  // ==========================================================================
  function automatic logic [QW-1:0] mag(input logic signed [DATA_W-1:0] v);
    mag = v[DATA_W-1] ? QW'(-{v[DATA_W-1], v}) : QW'(v);
  endfunction

  logic [QW-1:0] quantity;
  logic useLevel;
  logic flagCond;
  logic goSecond;
  logic goFirst;
  logic signed [QW:0] upperBound;
  logic signed [QW:0] lowerBound;
  assign upperBound = $signed({2'b00, switchLevel}) + $signed({2'b00, switchHyst});
  assign lowerBound = $signed({2'b00, switchLevel}) - $signed({2'b00, switchHyst});

  always_comb begin
    quantity = '0;
    useLevel = 1'b1;
    flagCond = 1'b0;
    case (condSel)
      SEL_TORQUE: quantity = torqueVar;
      SEL_VEL_CMD: quantity = mag(velocityCmd);
      SEL_SPEED: quantity = mag(motorSpeed);
      SEL_POS_DEV: quantity = mag(positionDeviation);
      SEL_POS_CMD: begin
        useLevel = 1'b0;
        flagCond = positionCmdActive;
      end
      SEL_NOT_DONE: begin
        useLevel = 1'b0;
        flagCond = !positioningDone;
      end
      default: begin
      end
    endcase
  end

  // The band between the two bounds holds the present set, which keeps the
  // selector from chattering around a single threshold.
  assign goSecond = useLevel ? ($signed({1'b0, quantity}) > upperBound) : flagCond;
  assign goFirst = useLevel ? ($signed({1'b0, quantity}) < lowerBound) : !flagCond;

  // ==========================================================================
  // Gain set selector
  // ==========================================================================
  gain_state_t gainState;
  logic [DATA_W-1:0] delayCnt;
  logic levelCond;
  always_comb begin
    case (condSel)
      SEL_TORQUE, SEL_VEL_CMD, SEL_POS_DEV, SEL_POS_CMD, SEL_NOT_DONE, SEL_SPEED: levelCond = 1'b1;
      default: levelCond = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      gainState <= GAIN_FIRST;
      delayCnt <= '0;
    end else if (!levelCond) begin
      gainState <= GAIN_FIRST;
      delayCnt <= '0;
    end else begin
      case (gainState)
        GAIN_FIRST: begin
          if (goSecond) begin
            gainState <= GAIN_SECOND;
          end
        end
        GAIN_SECOND: begin
          if (goFirst) begin
            gainState <= GAIN_RETURN;
            delayCnt <= switchDelay;
          end
        end
        GAIN_RETURN: begin
          if (goSecond) begin
            gainState <= GAIN_SECOND;
          end else if (delayCnt == '0) begin
            gainState <= GAIN_FIRST;
          end else if (windowTick) begin
            delayCnt <= delayCnt - 1'b1;
          end
        end
        default: begin
          gainState <= GAIN_FIRST;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      secondGain <= 1'b0;
    end else begin
      case (condSel)
        SEL_FIRST, SEL_FIRST_ALT: secondGain <= 1'b0;
        SEL_SECOND: secondGain <= 1'b1;
        SEL_INPUT: secondGain <= gainInput;
        default: secondGain <= levelCond && (gainState != GAIN_FIRST);
      endcase
    end
  end

  // ==========================================================================
  // Torque command filter
  // ==========================================================================
  // The time constant follows the active gain set; the divider reads it every cycle,
  // so a change during a divide acts on the step in progress, and 0 loads the input.
  logic [DATA_W-1:0] activeTc;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      activeTc <= RST_TC;
    end else begin
      activeTc <= secondGain ? secondTc : firstTc;
    end
  end

  torque_lpf #(
    .W(DATA_W),
    .FR(LPF_FRAC_W),
    .STEP(LPF_STEP_CYCLES)
  ) u_lpf (
    .ref_clk(ref_clk),
    .reset(reset),
    .timeConst(activeTc),
    .din(torqueCmd),
    .dout(torqueFiltered)
  );

  // ==========================================================================
  // Filter enables and status
  // ==========================================================================
  logic tuneAdaptive;
  assign tuneAdaptive = (tuningSetup != '0 && tuningSetup <= TUNE_MAX_LOW) || tuningSetup == TUNE_ALT;

  // Anti-vibration settings are taken as they stand; software only changes
  // them with the axis at rest, so no shadowing is done here.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      adaptiveNotchEn <= 1'b0;
      firstNotchEn <= 1'b0;
      realtimeTuningEn <= 1'b0;
      antiVibEn <= 1'b0;
      adaptIdx <= '0;
    end else begin
      adaptiveNotchEn <= tuneAdaptive && controlMode == MODE_FULL_POS;
      firstNotchEn <= controlMode != MODE_FAST_POS;
      realtimeTuningEn <= controlMode != MODE_FAST_POS && tuningSetup != '0;
      antiVibEn <= (controlMode == MODE_FAST_POS || controlMode == MODE_FULL_POS)
                   && vibFreq >= VIB_MIN_FREQ;
      adaptIdx <= adaptedIndex;
    end
  end

  always_comb begin
    statusWord = '0;
    statusWord[ST_SECOND] = secondGain;
    statusWord[ST_ADAPT] = adaptiveNotchEn;
    statusWord[ST_ANTIVIB] = antiVibEn;
    statusWord[ST_NOTCH] = firstNotchEn;
    statusWord[ST_RT_TUNE] = realtimeTuningEn;
  end
endmodule

// >>> servo_gain_pkg.sv
// Shared constants for the gain switching and filter control block.
package servo_gain_pkg;
  // ==========================================================================
  // Widths and timing
  // ==========================================================================
  localparam int DATA_W = 16;
  localparam int ADDR_W = 8;
  localparam int CLK_PERIOD_NS = 40;
  localparam int VAR_WINDOW_NS = 166000;
  localparam int VAR_WINDOW_CYCLES = VAR_WINDOW_NS / CLK_PERIOD_NS;
  localparam int LPF_STEP_NS = 10000;
  localparam int LPF_STEP_CYCLES = LPF_STEP_NS / CLK_PERIOD_NS;
  localparam int LPF_FRAC_W = 8;
  // ==========================================================================
  // Register byte offsets
  // ==========================================================================
  localparam logic [7:0] OFS_COND_SEL = 8'h00;
  localparam logic [7:0] OFS_DELAY = 8'h04;
  localparam logic [7:0] OFS_LEVEL = 8'h08;
  localparam logic [7:0] OFS_HYST = 8'h0c;
  localparam logic [7:0] OFS_TC1 = 8'h10;
  localparam logic [7:0] OFS_TC2 = 8'h14;
  localparam logic [7:0] OFS_RT_TUNE = 8'h18;
  localparam logic [7:0] OFS_ADAPT_IDX = 8'h1c;
  localparam logic [7:0] OFS_CTRL_MODE = 8'h20;
  localparam logic [7:0] OFS_NOTCH_FREQ = 8'h24;
  localparam logic [7:0] OFS_NOTCH_WIDTH = 8'h28;
  localparam logic [7:0] OFS_VIB_FREQ = 8'h2c;
  localparam logic [7:0] OFS_VIB_FILTER = 8'h30;
  localparam logic [7:0] OFS_STATUS = 8'h34;
  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [15:0] RST_COND_SEL = 16'h0007;
  localparam logic [15:0] RST_DELAY = 16'h001e;
  localparam logic [15:0] RST_LEVEL = 16'h0000;
  localparam logic [15:0] RST_HYST = 16'h0000;
  localparam logic [15:0] RST_TC = 16'h0041;
  localparam logic [15:0] RST_ZERO = 16'h0000;
  // ==========================================================================
  // Field codes and status bit positions
  // ==========================================================================
  localparam logic [15:0] SEL_FIRST = 16'h0000;
  localparam logic [15:0] SEL_SECOND = 16'h0001;
  localparam logic [15:0] SEL_INPUT = 16'h0002;
  localparam logic [15:0] SEL_TORQUE = 16'h0003;
  localparam logic [15:0] SEL_FIRST_ALT = 16'h0004;
  localparam logic [15:0] SEL_VEL_CMD = 16'h0005;
  localparam logic [15:0] SEL_POS_DEV = 16'h0006;
  localparam logic [15:0] SEL_POS_CMD = 16'h0007;
  localparam logic [15:0] SEL_NOT_DONE = 16'h0008;
  localparam logic [15:0] SEL_SPEED = 16'h0009;
  localparam logic [15:0] MODE_FAST_POS = 16'h0000;
  localparam logic [15:0] MODE_FULL_POS = 16'h0002;
  localparam logic [15:0] TUNE_MAX_LOW = 16'h0003;
  localparam logic [15:0] TUNE_ALT = 16'h0007;
  localparam logic [15:0] VIB_MIN_FREQ = 16'h0064;
  localparam int ST_SECOND = 0;
  localparam int ST_ADAPT = 1;
  localparam int ST_ANTIVIB = 2;
  localparam int ST_NOTCH = 3;
  localparam int ST_RT_TUNE = 4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {GAIN_FIRST, GAIN_SECOND, GAIN_RETURN} gain_state_t;
endpackage

// >>> torque_lpf.sv
// First-order torque command low-pass filter stepped every 10 us.
module torque_lpf #(
  parameter int W = 16,
  parameter int FR = 8,
  parameter int STEP = 250
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Filter data
  input wire logic [W-1:0] timeConst,
  input wire logic signed [W-1:0] din,
  output logic signed [W-1:0] dout
);
  localparam int AW = W + FR;
  localparam int CW = $clog2(STEP + 1);
  if (STEP <= AW + 1) begin : g_chk
    $error("torque_lpf: step too short for the divider");
  end
  logic signed [AW-1:0] acc;
  logic [AW-1:0] num;
  logic [W:0] rem;
  logic [W:0] trial;
  logic [CW-1:0] tickCnt;
  logic [$clog2(AW+1)-1:0] bitCnt;
  logic busy;
  logic neg;
  logic signed [AW:0] diff;
  assign diff = {din[W-1], din, {FR{1'b0}}} - {acc[AW-1], acc};
  assign trial = {rem[W-1:0], num[AW-1]} - {1'b0, timeConst};
  // ==========================================================================
  // Step timer and serial divide
  // ==========================================================================
  // Each step moves the output by diff/tc, so the time constant is tc steps of
  // 10 us and the cutoff is 1/(2*pi*tc*0.00001) Hz.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      acc <= '0;
      num <= '0;
      rem <= '0;
      tickCnt <= '0;
      bitCnt <= '0;
      busy <= 1'b0;
      neg <= 1'b0;
    end else begin
      tickCnt <= (tickCnt == CW'(STEP - 1)) ? '0 : tickCnt + 1'b1;
      if (busy) begin
        if (!trial[W]) begin
          rem <= trial;
        end else begin
          rem <= {rem[W-1:0], num[AW-1]};
        end
        num <= {num[AW-2:0], ~trial[W]};
        bitCnt <= bitCnt - 1'b1;
        if (bitCnt == 1) begin
          busy <= 1'b0;
        end
      end else if (bitCnt == 0 && tickCnt == 0) begin
        if (timeConst == '0) begin
          acc <= {din, {FR{1'b0}}};
        end else begin
          neg <= diff[AW];
          num <= diff[AW] ? AW'(-diff) : diff[AW-1:0];
          rem <= '0;
          bitCnt <= ($clog2(AW+1))'(AW);
          busy <= 1'b1;
        end
      end
      if (!busy && bitCnt == 0 && tickCnt == CW'(AW + 1)) begin
        acc <= neg ? acc - $signed(num) : acc + $signed(num);
        num <= '0;
      end
    end
  end
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      dout <= '0;
    end else begin
      dout <= acc[AW-1:FR];
    end
  end
endmodule

// >>> servo_gain_switch_filter_ctrl_assertions.sv
// Concurrent checks on the ports of the gain switch block.
module servo_gain_switch_filter_ctrl_assertions
  import servo_gain_pkg::*;
(
  // Clock, reset and bus handshakes
  input wire logic ref_clk, reset, awvalid, awready, wvalid, wready, bvalid, bready,
  input wire logic arvalid, arready, rvalid, rready,
  input wire logic [1:0] bresp, rresp,
  input wire logic [31:0] rdata,
  // Control outputs
  input wire logic antiVibEn, adaptiveNotchEn, firstNotchEn, realtimeTuningEn, secondGain,
  input wire logic [servo_gain_pkg::DATA_W-1:0] vibFreq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // ==========================================================================
  // Properties
  property p_vib; antiVibEn |-> $past(vibFreq) >= VIB_MIN_FREQ; endproperty
  a_vib: assert property (p_vib) else $error("antivib below min freq");
  property p_adapt; adaptiveNotchEn |-> realtimeTuningEn && firstNotchEn; endproperty
  a_adapt: assert property (p_adapt) else $error("adaptive notch outside mode");
  property p_fast; !firstNotchEn |-> !realtimeTuningEn; endproperty
  a_fast: assert property (p_fast) else $error("tuning on in fast mode");
  property p_bhold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped");
  property p_rhold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
  a_rhold: assert property (p_rhold) else $error("read answer dropped");
  property p_rerr; rvalid && rresp == RESP_SLVERR |-> rdata == 32'h0; endproperty
  a_rerr: assert property (p_rerr) else $error("error read not zero");
  property p_bans; awvalid && awready && wvalid && wready |-> ##2 bvalid; endproperty
  a_bans: assert property (p_bans) else $error("write answer late");
  property p_rans; arvalid && arready |=> rvalid; endproperty
  a_rans: assert property (p_rans) else $error("read answer late");
  c_gain: cover property ($rose(secondGain));
  c_vib: cover property (antiVibEn);
  c_adapt: cover property (adaptiveNotchEn);
endmodule
bind servo_gain_switch_filter_ctrl servo_gain_switch_filter_ctrl_assertions checker_i (.*);

// >>> servo_motor_model.sv
// Behavioural motor, encoder and notch estimator at the far side.
module servo_motor_model (
  input wire logic ref_clk, reset,
  input wire logic signed [15:0] speedTarget,
  output logic signed [15:0] motorSpeed,
  output logic positioningDone,
  output logic [15:0] adaptedIndex
);
  timeunit 1ns;
  timeprecision 1ns;
  // The shaft lags its target by a cycle, so speed switching sees a real delay.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      motorSpeed <= 16'sh0000;
      positioningDone <= 1'b1;
      adaptedIndex <= 16'h0023;
    end else begin
      motorSpeed <= speedTarget;
      positioningDone <= speedTarget == 16'sh0000;
    end
  end
endmodule

// >>> tb_top.sv
// Self-checking bench for the gain selector, torque filter and enables.
module tb_top;
  import servo_gain_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 0, reset = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic gainSwitchPin = 0, positionCmdActive = 0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'h3;
  logic signed [15:0] torqueCmd = 0, velocityCmd = 0, positionDeviation = 0, speedTarget = 0;
  logic signed [15:0] torqueFiltered, motorSpeed, v;
  logic awready, wready, bvalid, arready, rvalid, secondGain, positioningDone;
  logic adaptiveNotchEn, firstNotchEn, realtimeTuningEn, antiVibEn;
  logic [1:0] bresp, rresp;
  logic [15:0] notchFreq, notchWidth, vibFreq, vibFilter, adaptedIndex, t, f;
  int n_errors = 0, n_checks = 0;
  servo_gain_switch_filter_ctrl #(.VAR_WINDOW(20)) dut (.*);
  servo_motor_model motor (.*);
  initial forever #20 ref_clk = ~ref_clk;
  // ==========================================================================
  // Checks and tasks
  task automatic report_and_stop();
    if (n_errors == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, e);
    n_checks++;
    if (s !== e) begin
      n_errors++;
      $display("ERROR %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic hs(ref logic s);
    int i = 0;
    do begin @(posedge ref_clk); i++; end while (s !== 1'b1 && i < 50);
    if (s !== 1'b1) begin n_errors++; report_and_stop(); end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] r = RESP_OKAY);
    @(posedge ref_clk);
    awaddr <= a; wdata <= {16'h0000, d}; awvalid <= 1'b1; wvalid <= 1'b1;
    hs(wready);
    awvalid <= 1'b0; wvalid <= 1'b0;
    repeat (2) @(posedge ref_clk);
    bready <= 1'b1;
    hs(bvalid);
    bready <= 1'b0;
    chk("bresp", bresp, r);
  endtask
  task automatic rc(input logic [7:0] a, input logic [15:0] e, input logic [1:0] r = RESP_OKAY);
    @(posedge ref_clk);
    araddr <= a; arvalid <= 1'b1;
    hs(arready);
    arvalid <= 1'b0;
    @(posedge ref_clk);
    rready <= 1'b1;
    hs(rvalid);
    rready <= 1'b0;
    chk("rdata", rdata, {16'h0000, e});
    chk("rresp", rresp, r);
  endtask
  task automatic wg(input logic e, input int n);
    for (int i = 0; i < n && secondGain !== e; i++) @(posedge ref_clk);
    chk("secondGain", secondGain, e);
  endtask
  function automatic logic [3:0] en_exp(int m, int tu, int fr);
    return {m == 2 && (tu inside {1, 2, 3, 7}), (m == 0 || m == 2) && fr >= 100, m != 0, m != 0 && tu != 0};
  endfunction
  // ==========================================================================
  // Scenarios
  initial begin
    void'($urandom(21048));
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
    rc(OFS_COND_SEL, 16'h0007);
    rc(OFS_DELAY, 16'h001e);
    rc(OFS_TC2, 16'h0041);
    wr(OFS_ADAPT_IDX, 16'hffff);
    rc(OFS_ADAPT_IDX, 16'h0023);
    wr(8'h44, 16'h0001, RESP_SLVERR);
    rc(8'h40, 16'h0000, RESP_SLVERR);
    wr(OFS_TC1, 16'h0000);
    wr(OFS_TC2, 16'h0000);
    torqueCmd <= $urandom_range(0, 8000);
    repeat (300) @(posedge ref_clk);
    chk("torqueFiltered", torqueFiltered, torqueCmd);
    for (int k = 0; k < 5; k++) begin
      wr(OFS_COND_SEL, k == 3 ? SEL_INPUT : k == 4 ? SEL_FIRST_ALT : k[15:0]);
      gainSwitchPin <= k == 2 ? 1'b0 : k == 3 ? 1'b1 : 1'($urandom);
      wg(k == 1 || k == 3, 20);
    end
    wr(OFS_LEVEL, 16'd100);
    wr(OFS_HYST, 16'd10);
    wr(OFS_DELAY, 16'd2);
    for (int c = 5; c < 10; c++) begin
      wr(OFS_COND_SEL, c[15:0]);
      v = 111 + $urandom_range(0, 999);
      velocityCmd <= v; speedTarget <= v; positionDeviation <= -v; positionCmdActive <= 1'b1;
      wg(1'b1, 20);
      velocityCmd <= 0; speedTarget <= 0; positionDeviation <= 0; positionCmdActive <= 1'b0;
      repeat (10) @(posedge ref_clk);
      chk("secondGain", secondGain, 1'b1);
      wg(1'b0, 100);
    end
    wr(OFS_LEVEL, 16'd200);
    wr(OFS_HYST, 16'd0);
    wr(OFS_COND_SEL, SEL_TORQUE);
    torqueCmd <= torqueCmd + 16'sd2000;
    wg(1'b1, 80);
    wg(1'b0, 200);
    for (int k = 0; k < 12; k++) begin
      t = k == 2 ? 16'd7 : 16'($urandom_range(0, 7));
      f = 16'd99 + 16'(k % 2);
      wr(OFS_RT_TUNE, t);
      wr(OFS_CTRL_MODE, 16'(k % 3));
      wr(OFS_VIB_FREQ, f);
      repeat (2) @(posedge ref_clk);
      chk("enables", {adaptiveNotchEn, antiVibEn, firstNotchEn, realtimeTuningEn}, en_exp(k % 3, t, f));
    end
    report_and_stop();
  end
endmodule
